// [hdl/tta_consts.svh]
// Constants of the trigger timing alignment block
`ifndef TTA_CONSTS_SVH
`define TTA_CONSTS_SVH
`define TTA_CLK_MHZ 50
`define TTA_CLK_NS 20
`define TTA_BC_NS 25
`define TTA_DELAY_BITS 6
`define TTA_DELAY_STEP_PS 500
`define TTA_DELAY_SPAN_NS 25
`define TTA_PP_WIDTH_NS 100
`define TTA_PP_WIDTH_MIN_NS 50
`define TTA_PP_WIDTH_MAX_NS 300
`define TTA_PP_WIDTH_CYC ((`TTA_PP_WIDTH_NS + `TTA_CLK_NS - 1) / `TTA_CLK_NS)
`define TTA_PP_LEAD_NS (50 - 2 * `TTA_BC_NS)
`define TTA_PP_LEAD_RAW ((`TTA_PP_LEAD_NS + `TTA_CLK_NS - 1) / `TTA_CLK_NS)
`define TTA_PP_LEAD_CYC ((`TTA_PP_LEAD_RAW > 1) ? `TTA_PP_LEAD_RAW : 1)
`define TTA_SETTLE_US 1000
`define TTA_SETTLE_CYC (`TTA_SETTLE_US * `TTA_CLK_MHZ)
`define TTA_ADC_BITS 8
`define TTA_INH_BITS 12
`define TTA_SWITCH_BITS 5
`define TTA_REG_CTRL 4'h0
`define TTA_REG_DELAY 4'h1
`define TTA_REG_L1SEL 4'h2
`define TTA_REG_ORBSEL 4'h3
`define TTA_REG_INHIBIT 4'h4
`define TTA_REG_L1CONST 4'h5
`define TTA_REG_ORBCONST 4'h6
`define TTA_REG_STATUS 4'h7
`define TTA_REG_RESULT 4'h8
`define TTA_CTRL_START 0
`define TTA_CTRL_TEST 1
`define TTA_CTRL_EMUL 2
`endif

// [hdl/tta_pkg.sv]
// Types of the trigger timing alignment block
package tta_pkg;
   typedef enum logic [1:0] {
      TTA_SEL_TRIG = 2'h0,
      TTA_SEL_TRIG_REG = 2'h1,
      TTA_SEL_EMUL = 2'h2,
      TTA_SEL_EMUL_REG = 2'h3
   } tta_sel_t;
   typedef enum logic [2:0] {
      TTA_ST_IDLE = 3'h0,
      TTA_ST_SET = 3'h1,
      TTA_ST_SETTLE = 3'h3,
      TTA_ST_CONV = 3'h2,
      TTA_ST_EVAL = 3'h6,
      TTA_ST_L1 = 3'h7,
      TTA_ST_ORB = 3'h5
   } tta_state_t;
endpackage : tta_pkg

// [hdl/tta_link_if.sv]
// Link between alignment logic and its controller
`timescale 1ns/1ps
`include "tta_consts.svh"
interface tta_link_if;
   logic [`TTA_DELAY_BITS-1:0] delay_code;
   tta_pkg::tta_sel_t l1_sel;
   tta_pkg::tta_sel_t orbit_sel;
   logic test_sel;
   logic [`TTA_INH_BITS-1:0] inhibit_delay;
   logic conv_req;
   logic [`TTA_ADC_BITS-1:0] adc_result;
   logic adc_done;
   modport dev (input delay_code, l1_sel, orbit_sel, test_sel, inhibit_delay, conv_req,
                output adc_result, adc_done);
   modport ctl (output delay_code, l1_sel, orbit_sel, test_sel, inhibit_delay, conv_req,
                input adc_result, adc_done);
endinterface : tta_link_if

// [hdl/tta_device.sv]
// Timing alignment logic of the trigger distribution board
`timescale 1ns/1ps
`include "tta_consts.svh"
module tta_device #(
   parameter int DELAY_BITS = `TTA_DELAY_BITS,
   parameter int ADC_BITS = `TTA_ADC_BITS,
   parameter int INH_BITS = `TTA_INH_BITS
) (
   input wire logic clock,
   input wire logic reset_n,
   tta_link_if.dev link,
   input wire logic first_level_accept_trig,
   input wire logic first_level_accept_emul,
   input wire logic orbit_trig,
   input wire logic orbit_emul,
   input wire logic orbit_mark,
   input wire logic first_level_strobe,
   input wire logic first_level_serial_data,
   input wire logic second_level_strobe,
   input wire logic second_level_serial_data,
   input wire logic adc_sdata,
   output logic first_level_accept_out,
   output logic orbit_out,
   output logic early_orbit_pulse,
   output logic [DELAY_BITS-1:0] front_panel_phase_switch_code,
   output logic first_level_strobe_out,
   output logic first_level_data_out,
   output logic second_level_strobe_out,
   output logic second_level_data_out,
   output logic adc_cs_n,
   output logic adc_sclk
);
   localparam int PP_WIDTH = `TTA_PP_WIDTH_CYC;
   localparam int PP_LEAD = `TTA_PP_LEAD_CYC;
   localparam logic [INH_BITS-1:0] LEAD_W = INH_BITS'(PP_LEAD);
   localparam logic [3:0] WIDTH_W = 4'(PP_WIDTH);

   ////////////////////////////////////////////////////////////////////////////
   // Falling edge resampling
   logic l1_trig_q, l1_trig_d, l1_emul_q, l1_emul_d;
   logic orb_trig_q, orb_trig_d, orb_emul_q, orb_emul_d;
   logic l1s_q, l1s_d, l1dat_q, l1dat_d, l2s_q, l2s_d, l2dat_q, l2dat_d;
   logic sq_q, sq_d;

   always_comb begin
      l1_trig_d = first_level_accept_trig;
      l1_emul_d = first_level_accept_emul;
      orb_trig_d = orbit_trig;
      orb_emul_d = orbit_emul;
      l1s_d = first_level_strobe;
      l2s_d = second_level_strobe;
      l2dat_d = second_level_serial_data;
      sq_d = link.test_sel ? ~sq_q : 1'b0;
      l1dat_d = link.test_sel ? ~sq_q : first_level_serial_data;
   end

   always_ff @(negedge clock or negedge reset_n) begin
      if (!reset_n) begin
         l1_trig_q <= 1'b0;
         l1_emul_q <= 1'b0;
         orb_trig_q <= 1'b0;
         orb_emul_q <= 1'b0;
         l1s_q <= 1'b0;
         l1dat_q <= 1'b0;
         l2s_q <= 1'b0;
         l2dat_q <= 1'b0;
         sq_q <= 1'b0;
      end else begin
         l1_trig_q <= l1_trig_d;
         l1_emul_q <= l1_emul_d;
         orb_trig_q <= orb_trig_d;
         orb_emul_q <= orb_emul_d;
         l1s_q <= l1s_d;
         l1dat_q <= l1dat_d;
         l2s_q <= l2s_d;
         l2dat_q <= l2dat_d;
         sq_q <= sq_d;
      end
   end

   assign first_level_strobe_out = l1s_q;
   assign first_level_data_out = l1dat_q;
   assign second_level_strobe_out = l2s_q;
   assign second_level_data_out = l2dat_q;

   ////////////////////////////////////////////////////////////////////////////
   // Output version selectors
   // four-way selector
   always_comb begin
      case (link.l1_sel)
         tta_pkg::TTA_SEL_TRIG: first_level_accept_out = first_level_accept_trig;
         tta_pkg::TTA_SEL_TRIG_REG: first_level_accept_out = l1_trig_q;
         tta_pkg::TTA_SEL_EMUL: first_level_accept_out = first_level_accept_emul;
         default: first_level_accept_out = l1_emul_q;
      endcase
      case (link.orbit_sel)
         tta_pkg::TTA_SEL_TRIG: orbit_out = orbit_trig;
         tta_pkg::TTA_SEL_TRIG_REG: orbit_out = orb_trig_q;
         tta_pkg::TTA_SEL_EMUL: orbit_out = orbit_emul;
         default: orbit_out = orb_emul_q;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock delay code and early orbit pulse
   logic [DELAY_BITS-1:0] dly_q, dly_d;
   logic [INH_BITS-1:0] ocnt_q, ocnt_d;
   logic orun_q, orun_d;
   logic [3:0] pw_q, pw_d;
   logic pp_q, pp_d;

   always_comb begin
      dly_d = link.delay_code;
      ocnt_d = ocnt_q;
      orun_d = orun_q;
      pw_d = pw_q;
      pp_d = pp_q;
      if (orbit_mark) begin
         ocnt_d = '0;
         orun_d = 1'b1;
      end else if (orun_q) begin
         ocnt_d = ocnt_q + 1'b1;
      end
      if (orun_q && !orbit_mark && (ocnt_q + LEAD_W >= link.inhibit_delay)) begin
         orun_d = 1'b0;
         pp_d = 1'b1;
         pw_d = WIDTH_W - 4'h1;
      end else if (pp_q) begin
         if (pw_q == 4'h0) begin
            pp_d = 1'b0;
         end else begin
            pw_d = pw_q - 4'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dly_q <= '0;
         ocnt_q <= '0;
         orun_q <= 1'b0;
         pw_q <= 4'h0;
         pp_q <= 1'b0;
      end else begin
         dly_q <= dly_d;
         ocnt_q <= ocnt_d;
         orun_q <= orun_d;
         pw_q <= pw_d;
         pp_q <= pp_d;
      end
   end

   assign front_panel_phase_switch_code = dly_q;
   assign early_orbit_pulse = pp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Serial converter reader
   logic cs_q, cs_d, sclk_q, sclk_d, done_q, done_d;
   logic [3:0] bit_q, bit_d;
   logic [ADC_BITS-1:0] sh_q, sh_d, res_q, res_d;

   always_comb begin
      cs_d = cs_q;
      sclk_d = 1'b0;
      bit_d = bit_q;
      sh_d = sh_q;
      res_d = res_q;
      done_d = 1'b0;
      if (!cs_q) begin
         sclk_d = ~sclk_q;
         if (sclk_q) begin
            sh_d = {sh_q[ADC_BITS-2:0], adc_sdata};
            if (bit_q == 4'(ADC_BITS - 1)) begin
               cs_d = 1'b1;
               sclk_d = 1'b0;
               res_d = {sh_q[ADC_BITS-2:0], adc_sdata};
               done_d = 1'b1;
            end else begin
               bit_d = bit_q + 4'h1;
            end
         end
      end else if (link.conv_req) begin
         cs_d = 1'b0;
         bit_d = 4'h0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cs_q <= 1'b1;
         sclk_q <= 1'b0;
         bit_q <= 4'h0;
         sh_q <= '0;
         res_q <= '0;
         done_q <= 1'b0;
      end else begin
         cs_q <= cs_d;
         sclk_q <= sclk_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         res_q <= res_d;
         done_q <= done_d;
      end
   end

   assign adc_cs_n = cs_q;
   assign adc_sclk = sclk_q;
   assign link.adc_result = res_q;
   assign link.adc_done = done_q;
endmodule : tta_device

// [hdl/tta_controller.sv]
// Controller end: registers and automatic delay scan
`timescale 1ns/1ps
`include "tta_consts.svh"
module tta_controller #(
   parameter int DELAY_BITS = `TTA_DELAY_BITS,
   parameter int ADC_BITS = `TTA_ADC_BITS,
   parameter int SETTLE_CYC = `TTA_SETTLE_CYC
) (
   input wire logic clock,
   input wire logic reset_n,
   tta_link_if.ctl link,
   input wire logic [`TTA_SWITCH_BITS-1:0] front_panel_phase_switch,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam logic [DELAY_BITS-1:0] DMAX = '1;
   logic [DELAY_BITS-1:0] dly_q, dly_d, dmax_q, dmax_d, dmin_q, dmin_d;
   logic [ADC_BITS-1:0] vmax_q, vmax_d, vmin_q, vmin_d, last_q, last_d;
   tta_pkg::tta_sel_t l1_q, l1_d, orb_q, orb_d;
   tta_pkg::tta_state_t st_q, st_d;
   logic [DELAY_BITS:0] l1c_q, l1c_d, orc_q, orc_d, sum;
   logic [`TTA_INH_BITS-1:0] inh_q, inh_d;
   logic [16:0] cnt_q, cnt_d;
   logic test_q, test_d, emul_q, emul_d, req_q, req_d, done_q, done_d;
   logic wait_q, wait_d;
   logic [31:0] rd_q, rd_d;
   logic wr_take, rd_take, busy;

   assign busy = (st_q != tta_pkg::TTA_ST_IDLE);
   assign wr_take = avs_write && !wait_q;
   assign rd_take = avs_read && wait_q;

   always_comb begin
      wait_d = wait_q ? !(avs_read || avs_write) : 1'b1;
      rd_d = rd_q;
      if (rd_take) begin
         case (avs_address)
            `TTA_REG_CTRL: rd_d = {29'h0, emul_q, test_q, busy};
            `TTA_REG_DELAY: rd_d = {26'h0, dly_q};
            `TTA_REG_L1SEL: rd_d = {30'h0, l1_q};
            `TTA_REG_ORBSEL: rd_d = {30'h0, orb_q};
            `TTA_REG_INHIBIT: rd_d = {20'h0, inh_q};
            `TTA_REG_L1CONST: rd_d = {25'h0, l1c_q};
            `TTA_REG_ORBCONST: rd_d = {25'h0, orc_q};
            `TTA_REG_STATUS: rd_d = {22'h0, front_panel_phase_switch, 3'h0, done_q, busy};
            `TTA_REG_RESULT: rd_d = {4'h0, dmax_q, dmin_q, vmax_q, last_q};
            default: rd_d = 32'h0;
         endcase
      end
   end

   always_comb begin
      st_d = st_q;
      dly_d = dly_q;
      l1_d = l1_q;
      orb_d = orb_q;
      l1c_d = l1c_q;
      orc_d = orc_q;
      inh_d = inh_q;
      test_d = test_q;
      emul_d = emul_q;
      cnt_d = cnt_q;
      req_d = 1'b0;
      done_d = done_q;
      dmax_d = dmax_q;
      dmin_d = dmin_q;
      vmax_d = vmax_q;
      vmin_d = vmin_q;
      last_d = last_q;
      sum = '0;
      if (wr_take && !busy) begin
         case (avs_address)
            `TTA_REG_CTRL: begin
               test_d = avs_writedata[`TTA_CTRL_TEST];
               emul_d = avs_writedata[`TTA_CTRL_EMUL];
               if (avs_writedata[`TTA_CTRL_START]) begin
                  st_d = tta_pkg::TTA_ST_SET;
                  dly_d = '0;
                  test_d = 1'b1;
                  done_d = 1'b0;
                  vmax_d = '0;
                  vmin_d = '1;
               end
            end
            `TTA_REG_DELAY: dly_d = avs_writedata[DELAY_BITS-1:0];
            `TTA_REG_L1SEL: l1_d = tta_pkg::tta_sel_t'(avs_writedata[1:0]);
            `TTA_REG_ORBSEL: orb_d = tta_pkg::tta_sel_t'(avs_writedata[1:0]);
            `TTA_REG_INHIBIT: inh_d = avs_writedata[`TTA_INH_BITS-1:0];
            `TTA_REG_L1CONST: l1c_d = avs_writedata[DELAY_BITS:0];
            `TTA_REG_ORBCONST: orc_d = avs_writedata[DELAY_BITS:0];
            default: ;
         endcase
      end
      case (st_q)
         tta_pkg::TTA_ST_IDLE: ;
         tta_pkg::TTA_ST_SET: begin
            cnt_d = 17'(SETTLE_CYC - 1);
            st_d = tta_pkg::TTA_ST_SETTLE;
         end
         tta_pkg::TTA_ST_SETTLE: begin
            if (cnt_q == 17'h0) begin
               req_d = 1'b1;
               st_d = tta_pkg::TTA_ST_CONV;
            end else begin
               cnt_d = cnt_q - 17'h1;
            end
         end
         tta_pkg::TTA_ST_CONV: begin
            if (link.adc_done) begin
               last_d = link.adc_result;
               st_d = tta_pkg::TTA_ST_EVAL;
            end
         end
         tta_pkg::TTA_ST_EVAL: begin
            if (last_q > vmax_q) begin
               vmax_d = last_q;
               dmax_d = dly_q;
            end
            if (last_q < vmin_q) begin
               vmin_d = last_q;
               dmin_d = dly_q;
            end
            if (dly_q == DMAX) begin
               st_d = tta_pkg::TTA_ST_L1;
               test_d = 1'b0;
               dly_d = (dmax_d < dmin_d) ? dmax_d : dmin_d;
            end else begin
               dly_d = dly_q + 1'b1;
               st_d = tta_pkg::TTA_ST_SET;
            end
         end
         tta_pkg::TTA_ST_L1: begin
            sum = {1'b0, dly_q} + l1c_q;
            l1_d = tta_pkg::tta_sel_t'({emul_q, sum[DELAY_BITS-1]});
            st_d = tta_pkg::TTA_ST_ORB;
         end
         tta_pkg::TTA_ST_ORB: begin
            sum = {1'b0, dly_q} + orc_q + (DELAY_BITS+1)'(front_panel_phase_switch);
            orb_d = tta_pkg::tta_sel_t'({emul_q, sum[DELAY_BITS-1]});
            done_d = 1'b1;
            st_d = tta_pkg::TTA_ST_IDLE;
         end
         default: st_d = tta_pkg::TTA_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= tta_pkg::TTA_ST_IDLE;
         dly_q <= '0;
         l1_q <= tta_pkg::TTA_SEL_TRIG;
         orb_q <= tta_pkg::TTA_SEL_TRIG;
         l1c_q <= '0;
         orc_q <= '0;
         inh_q <= '0;
         test_q <= 1'b0;
         emul_q <= 1'b0;
         cnt_q <= 17'h0;
         req_q <= 1'b0;
         done_q <= 1'b0;
         dmax_q <= '0;
         dmin_q <= '0;
         vmax_q <= '0;
         vmin_q <= '1;
         last_q <= '0;
         wait_q <= 1'b1;
         rd_q <= 32'h0;
      end else begin
         st_q <= st_d;
         dly_q <= dly_d;
         l1_q <= l1_d;
         orb_q <= orb_d;
         l1c_q <= l1c_d;
         orc_q <= orc_d;
         inh_q <= inh_d;
         test_q <= test_d;
         emul_q <= emul_d;
         cnt_q <= cnt_d;
         req_q <= req_d;
         done_q <= done_d;
         dmax_q <= dmax_d;
         dmin_q <= dmin_d;
         vmax_q <= vmax_d;
         vmin_q <= vmin_d;
         last_q <= last_d;
         wait_q <= wait_d;
         rd_q <= rd_d;
      end
   end

   assign link.delay_code = dly_q;
   assign link.l1_sel = l1_q;
   assign link.orbit_sel = orb_q;
   assign link.test_sel = test_q;
   assign link.inhibit_delay = inh_q;
   assign link.conv_req = req_q;
   assign avs_readdata = rd_q;
   assign avs_waitrequest = wait_q;
endmodule : tta_controller

// [dv/tta_alignment_props.sv]
// Concurrent checks on the alignment link and device outputs
`timescale 1ns/1ps
`include "tta_consts.svh"
module tta_alignment_props #(
   parameter int SETTLE_CYC = `TTA_SETTLE_CYC
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [`TTA_DELAY_BITS-1:0] delay_code,
   input wire logic test_sel,
   input wire logic [`TTA_INH_BITS-1:0] inhibit_delay,
   input wire logic conv_req,
   input wire logic adc_done,
   input wire logic orbit_mark,
   input wire logic early_orbit_pulse,
   input wire logic adc_cs_n,
   input wire logic first_level_data_out
);
   //////////////////////////////////////////////////
   logic [15:0] orb_cnt_q;
   logic [15:0] orb_cnt_d;
   logic [15:0] stab_q;
   logic [15:0] stab_d;
   logic [`TTA_DELAY_BITS-1:0] dly_q;
   // Cycles since orbit mark and since delay change
   always_comb begin
      orb_cnt_d = orbit_mark ? 16'h0 : orb_cnt_q + {15'h0, ~&orb_cnt_q};
      stab_d = (delay_code != dly_q) ? 16'h0 : stab_q + {15'h0, ~&stab_q};
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         orb_cnt_q <= 16'h0;
         stab_q <= 16'h0;
         dly_q <= '0;
      end else begin
         orb_cnt_q <= orb_cnt_d;
         stab_q <= stab_d;
         dly_q <= delay_code;
      end
   end
   //////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   AST_PULSE_WIDTH: assert property ($rose(early_orbit_pulse) |->
      early_orbit_pulse[*5] ##1 !early_orbit_pulse) else $error("early pulse width wrong");
   AST_PULSE_LEAD: assert property ($rose(early_orbit_pulse) |->
      orb_cnt_q <= {4'h0, inhibit_delay}) else $error("early pulse too late");
   AST_CONV_SELECT: assert property (conv_req |=> !adc_cs_n)
      else $error("converter not selected");
   AST_CONV_DONE: assert property (conv_req |-> ##[2:40] adc_done)
      else $error("conversion did not finish");
   AST_CONV_RELEASE: assert property (adc_done |-> ##[0:1] adc_cs_n)
      else $error("converter still selected");
   AST_SQUARE_WAVE: assert property (test_sel && $past(test_sel) |->
      first_level_data_out != $past(first_level_data_out)) else $error("no toggle in test");
   AST_SETTLE: assert property (conv_req |-> stab_q >= 16'(SETTLE_CYC - 1))
      else $error("conversion before settling");
   AST_SCAN_TEST: assert property (conv_req |-> test_sel)
      else $error("conversion outside test mode");
   cover property ($rose(early_orbit_pulse));
   cover property (adc_done);
   cover property ($fell(test_sel));
endmodule : tta_alignment_props

// [dv/trigger_timing_alignment_tb.sv]
// Bench joining the device and controller ends of the timing link
`timescale 1ns/1ps
`include "tta_consts.svh"
module trigger_timing_alignment_tb;
   localparam int SETTLE = 4;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic acc_trig = 1'b0;
   logic acc_emul = 1'b1;
   logic orb_trig = 1'b0;
   logic orb_emul = 1'b1;
   logic orbit_mark = 1'b0;
   logic st1 = 1'b0;
   logic sd1 = 1'b1;
   logic st2 = 1'b0;
   logic sd2 = 1'b1;
   logic [`TTA_SWITCH_BITS-1:0] fp_switch = 5'h04;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic acc_out, orb_out, eop, st1_out, sd1_out, st2_out, sd2_out, adc_cs_n, adc_sclk;
   logic [5:0] bc_dly;
   logic adc_sdata;
   logic [7:0] lev;
   logic [2:0] bit_q = 3'h0;
   logic tog_q = 1'b0;
   int num_errors = 0;
   int num_checks = 0;
   logic [3:0] ra [6] = '{`TTA_REG_DELAY, `TTA_REG_L1SEL, `TTA_REG_ORBSEL,
                          `TTA_REG_INHIBIT, `TTA_REG_L1CONST, `TTA_REG_ORBCONST};
   logic [31:0] wd [6] = '{32'hffffffff, 32'h2, 32'h3, 32'ha, 32'h19, 32'h3};
   logic [31:0] ex [6] = '{32'h3f, 32'h2, 32'h3, 32'ha, 32'h19, 32'h3};
   always #10 clock = ~clock;
   //////////////////////////////////////////////////
   tta_link_if u_tta_link_if ();
   tta_device u_tta_device (.clock(clock), .reset_n(reset_n), .link(u_tta_link_if.dev),
      .first_level_accept_trig(acc_trig), .first_level_accept_emul(acc_emul),
      .orbit_trig(orb_trig), .orbit_emul(orb_emul), .orbit_mark(orbit_mark),
      .first_level_strobe(st1), .first_level_serial_data(sd1),
      .second_level_strobe(st2), .second_level_serial_data(sd2), .adc_sdata(adc_sdata),
      .first_level_accept_out(acc_out), .orbit_out(orb_out), .early_orbit_pulse(eop),
      .front_panel_phase_switch_code(bc_dly), .first_level_strobe_out(st1_out),
      .first_level_data_out(sd1_out), .second_level_strobe_out(st2_out),
      .second_level_data_out(sd2_out), .adc_cs_n(adc_cs_n), .adc_sclk(adc_sclk));
   tta_controller #(.SETTLE_CYC(SETTLE)) u_tta_controller (.clock(clock),
      .reset_n(reset_n), .link(u_tta_link_if.ctl), .front_panel_phase_switch(fp_switch),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   tta_alignment_props #(.SETTLE_CYC(SETTLE)) u_tta_alignment_props (.clock(clock),
      .reset_n(reset_n), .delay_code(u_tta_link_if.delay_code),
      .test_sel(u_tta_link_if.test_sel), .inhibit_delay(u_tta_link_if.inhibit_delay),
      .conv_req(u_tta_link_if.conv_req), .adc_done(u_tta_link_if.adc_done),
      .orbit_mark(orbit_mark), .early_orbit_pulse(eop), .adc_cs_n(adc_cs_n),
      .first_level_data_out(sd1_out));
   // Overlap level with one minimum at delay 12
   assign lev = 8'(10 + 4 * ((bc_dly > 6'hc) ? bc_dly - 6'hc : 6'hc - bc_dly));
   assign adc_sdata = adc_cs_n ? tog_q : lev[3'h7 - bit_q];
   always @(posedge clock) begin
      tog_q <= ~tog_q;
      if (adc_cs_n)
         bit_q <= 3'h0;
      else if (adc_sclk)
         bit_q <= bit_q + 3'h1;
   end
   //////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      av(1'b1, a, d, q);
   endtask : wr
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      av(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rd_chk
   task automatic wrap_up();
      if (num_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (40000) @(posedge clock);
      num_errors++;
      wrap_up();
   end
   //////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic [3:0] o;
      logic t;
      int n;
      int m;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      rd_chk(`TTA_REG_CTRL, 32'h0);
      rd_chk(`TTA_REG_STATUS, 32'h80);
      rd_chk(4'hf, 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr(ra[i], wd[i]);
         rd_chk(ra[i], ex[i]);
      end
      wr(`TTA_REG_STATUS, 32'hffffffff);
      rd_chk(`TTA_REG_STATUS, 32'h80);
      chk({26'h0, bc_dly}, 32'h3f);
      for (int s = 0; s < 4; s++) begin
         wr(`TTA_REG_L1SEL, s);
         wr(`TTA_REG_ORBSEL, s);
         t = acc_trig;
         @(posedge clock);
         acc_trig <= !t;
         acc_emul <= t;
         orb_trig <= !t;
         orb_emul <= t;
         #1;
         chk({acc_out, orb_out}, {2{t ^ !(s[0] ^ s[1])}});
         @(negedge clock);
         #1;
         chk({acc_out, orb_out}, {2{t ^ !s[1]}});
      end
      repeat (2) begin
         @(posedge clock);
         o = {st1, sd1, st2, sd2};
         {st1, sd1, st2, sd2} <= ~o;
         #1;
         chk({st1_out, sd1_out, st2_out, sd2_out}, o);
         @(negedge clock);
         #1;
         chk({st1_out, sd1_out, st2_out, sd2_out}, 4'(~o));
      end
      wr(`TTA_REG_CTRL, 32'h2);
      rd_chk(`TTA_REG_CTRL, 32'h2);
      @(negedge clock);
      #1;
      repeat (4) begin
         t = sd1_out;
         @(negedge clock);
         #1;
         chk(sd1_out, !t);
      end
      wr(`TTA_REG_CTRL, 32'h0);
      repeat (2) @(negedge clock);
      #1;
      chk(sd1_out, sd1);
      // early pulse against inhibit of 10
      @(posedge clock);
      orbit_mark <= 1'b1;
      @(posedge clock);
      orbit_mark <= 1'b0;
      n = 0;
      while (eop !== 1'b1 && n < 50) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(32'(n > 0 && n <= 10), 32'h1);
      m = 0;
      while (eop === 1'b1 && m < 50) begin
         @(posedge clock);
         #1;
         m++;
      end
      chk(m, 32'h5);
      for (int e = 0; e < 2; e++) begin
         wr(`TTA_REG_CTRL, {29'h0, e[0], 2'b01});
         rd_chk(`TTA_REG_CTRL, {29'h0, e[0], 2'b11});
         wr(`TTA_REG_L1CONST, 32'h0);
         n = 0;
         do begin
            av(1'b0, `TTA_REG_STATUS, 32'h0, q);
            n++;
         end while (q[0] !== 1'b0 && n < 3000);
         chk(q, 32'h82);
         rd_chk(`TTA_REG_DELAY, 32'hc);
         rd_chk(`TTA_REG_RESULT, {4'h0, 6'h3f, 6'hc, 8'hd6, 8'hd6});
         rd_chk(`TTA_REG_L1SEL, {30'h0, e[0], 1'b1});
         rd_chk(`TTA_REG_ORBSEL, {30'h0, e[0], 1'b0});
         rd_chk(`TTA_REG_L1CONST, 32'h19);
         chk({26'h0, bc_dly}, 32'hc);
      end
      wrap_up();
   end
endmodule : trigger_timing_alignment_tb
